/* File: logic/dcc_pkg.sv */
package dcc_pkg;

	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [9:0] CMP_ONE_CTRL_IDX = 10'h0ac;
	localparam logic [9:0] CMP_TWO_CTRL_IDX = 10'h0ad;
	localparam logic [9:0] PORT0_DIG_IN_DIS_IDX = 10'h0f6;
	localparam logic [9:0] PORT0_PIN_READ_IDX = 10'h080;
	localparam logic [9:0] CMP_INT_CTRL_IDX = 10'h0e0;

	// ----------------------------------------
	// Comparator control fields
	// ----------------------------------------
	localparam int CTRL_ENABLE_BIT = 5;
	localparam int CTRL_POS_SEL_BIT = 4;
	localparam int CTRL_NEG_SEL_BIT = 3;
	localparam int CTRL_PIN_OE_BIT = 2;
	localparam int CTRL_RESULT_BIT = 1;
	localparam int CTRL_FLAG_BIT = 0;

	// Interrupt control fields
	localparam int INT_GLOBAL_EN_BIT = 0;
	localparam int INT_CMP_EN_LSB = 1;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] PORT0_DIS_RESET = 8'h00;
	localparam logic [2:0] INT_CTRL_RESET = 3'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int SETTLE_TIME_NS = 10000;
	localparam int SETTLE_CYCLES = (SETTLE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ----------------------------------------
	// Bus responses
	// ----------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* File: logic/dcc_top.sv */
`timescale 1ns/10ps
// Summary of operation
// RULE1: Two comparators, each with its own identically laid out control register.
// RULE2: Control registers at indices ACh and ADh; no single-bit addressing.
// RULE3: Result is one when selected positive input exceeds selected negative input.
// RULE4: Bit 5 enables comparator; result trusted only 10 us after enabling.
// RULE5: Bits 4, 3, 2 together pick one of eight configurations.
// RULE6: Positive input chosen from two pins by positive select.
// RULE7: Negative input is external reference pin or internal reference by bit 3.
// RULE8: Positive select 0 first pin, 1 second; negative 0 pin, 1 internal.
// RULE9: With bit 2 set and enabled, raw result drives output pin unsynchronized.
// RULE10: Bit 1 reads result synchronized to clock; zero while disabled.
// RULE11: Each comparator can request an interrupt when its result changes.
// RULE12: Bit 0 flag sets on each change; request only with both enables set.
// RULE13: Service routine clears the change flag by writing zero before returning.
// RULE14: Software keeps interrupt off while settling and clears flag before enabling.
// RULE15: Software writes no ones to bits 7 and 6; they read zero here.
// RULE16: Port 0 input disable register, one bit per pin, disconnects input buffer.
// RULE17: Reading a disabled port 0 pin returns zero for that bit.
// RULE18: Software disables digital output and input of analog comparator pins.
module dcc_top
	import dcc_pkg::*;
#(
	parameter int ANA_W = 8,
	parameter logic [ANA_W-1:0] VREF_CODE = 8'h80,
	parameter int ADDR_W = 12
) (
	input wire logic clock,
	input wire logic nrst,
	// AXI4-Lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Analog levels, comparator n in slice n of each positive pin; one reference shared by both
	input wire logic [2*ANA_W-1:0] posPinA,
	input wire logic [2*ANA_W-1:0] posPinB,
	input wire logic [ANA_W-1:0] externalReferencePin,
	// Port 0 pins and input buffer control
	input wire logic [7:0] port0Pins,
	output logic [7:0] port0InputBufferEnable,
	// Comparator pin outputs
	output logic [1:0] comparatorPinOut,
	output logic [1:0] comparatorPinOutEnable,
	// Interrupt requests toward the CPU
	output logic [1:0] comparatorIrq
);

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rstMeta_ff;
	logic rstN_ff;

	// Asynchronous assert, two-flop release
	always_ff @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			rstMeta_ff <= 1'b0;
			rstN_ff <= 1'b0;
		end else begin
			rstMeta_ff <= 1'b1;
			rstN_ff <= rstMeta_ff;
		end
	end

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	logic [1:0] enable_ff;
	logic [1:0] posSel_ff;
	logic [1:0] negSel_ff;
	logic [1:0] pinOe_ff;
	logic [1:0] flag_ff;
	logic [1:0] result_ff;
	logic [7:0] port0Disable_ff;
	logic [2:0] intCtrl_ff;
	logic [7:0] port0Read_ff;

	// ----------------------------------------
	// AXI4-Lite write channel
	// ----------------------------------------
	logic awHeld_ff;
	logic wHeld_ff;
	logic [ADDR_W-1:0] awAddr_ff;
	logic [31:0] wData_ff;
	logic [3:0] wStrb_ff;
	logic doWrite;
	logic [9:0] wIndex;
	logic wAligned;
	logic wMapped;
	logic wLane0;

	assign doWrite = awHeld_ff && wHeld_ff && !s_axi_bvalid;
	assign wIndex = awAddr_ff[11:2];
	assign wAligned = (awAddr_ff[1:0] == 2'h0);
	assign wLane0 = wStrb_ff[0];
	assign wMapped = wAligned && (wIndex == CMP_ONE_CTRL_IDX || wIndex == CMP_TWO_CTRL_IDX ||
		wIndex == PORT0_DIG_IN_DIS_IDX || wIndex == PORT0_PIN_READ_IDX ||
		wIndex == CMP_INT_CTRL_IDX);

	// Address capture, released when the response is taken
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			awHeld_ff <= 1'b0;
			awAddr_ff <= '0;
			s_axi_awready <= 1'b0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			awHeld_ff <= 1'b0;
			s_axi_awready <= 1'b1;
		end else if (!awHeld_ff) begin
			s_axi_awready <= 1'b1;
		end
	end

	// Data capture, independent of address order
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			wHeld_ff <= 1'b0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			s_axi_wready <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
			s_axi_wready <= 1'b0;
		end else if (s_axi_bvalid && s_axi_bready) begin
			wHeld_ff <= 1'b0;
			s_axi_wready <= 1'b1;
		end else if (!wHeld_ff) begin
			s_axi_wready <= 1'b1;
		end
	end

	// Write response after both halves held
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Plain control registers
	// ----------------------------------------
	logic wrPort0Dis;
	logic wrIntCtrl;

	assign wrPort0Dis = doWrite && wAligned && wLane0 && wIndex == PORT0_DIG_IN_DIS_IDX;
	assign wrIntCtrl = doWrite && wAligned && wLane0 && wIndex == CMP_INT_CTRL_IDX;

	// Port 0 digital input disable
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			port0Disable_ff <= PORT0_DIS_RESET;
		end else if (wrPort0Dis) begin
			port0Disable_ff <= wData_ff[7:0]; // RULE16
		end
	end

	// Interrupt enables, global and per comparator
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			intCtrl_ff <= INT_CTRL_RESET;
		end else if (wrIntCtrl) begin
			intCtrl_ff <= wData_ff[2:0];
		end
	end

	// Buffer enables follow the disable bits; disabled pins read zero
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			port0InputBufferEnable <= 8'hff;
			port0Read_ff <= 8'h00;
		end else begin
			port0InputBufferEnable <= ~port0Disable_ff; // RULE16
			port0Read_ff <= port0Pins & ~port0Disable_ff; // RULE17
		end
	end

	// ----------------------------------------
	// Per-comparator logic
	// ----------------------------------------
	localparam logic [9:0] CTRL_IDX [2] = '{CMP_ONE_CTRL_IDX, CMP_TWO_CTRL_IDX};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : gCmp
			logic [ANA_W-1:0] posLevel;
			logic [ANA_W-1:0] negLevel;
			logic rawResult;
			logic syncMeta_ff;
			logic syncStage_ff;
			logic settled;
			logic [9:0] settleCnt_ff;
			logic wrCtrl;
			logic hwChange;

			// Input selection and raw compare
			assign posLevel = posSel_ff[gi] ? posPinB[gi*ANA_W +: ANA_W]
				: posPinA[gi*ANA_W +: ANA_W]; // RULE6 RULE8
			assign negLevel = negSel_ff[gi] ? VREF_CODE : externalReferencePin; // RULE7 RULE8
			assign rawResult = enable_ff[gi] && (posLevel > negLevel); // RULE3 RULE5

			// Raw result to pin without clock sync
			assign comparatorPinOut[gi] = rawResult && pinOe_ff[gi]; // RULE9

			// Two-flop synchroniser of the raw result
			always_ff @(posedge clock or negedge rstN_ff) begin
				if (!rstN_ff) begin
					syncMeta_ff <= 1'b0;
					syncStage_ff <= 1'b0;
				end else begin
					syncMeta_ff <= rawResult;
					syncStage_ff <= syncMeta_ff;
				end
			end

			// Settle timer restarts on every fresh enable
			always_ff @(posedge clock or negedge rstN_ff) begin
				if (!rstN_ff) begin
					settleCnt_ff <= '0;
				end else if (!enable_ff[gi]) begin
					settleCnt_ff <= '0;
				end else if (!settled) begin
					settleCnt_ff <= settleCnt_ff + 10'h001; // RULE4
				end
			end
			assign settled = (settleCnt_ff == 10'(SETTLE_CYCLES));

			// Readable result, zero while disabled or settling
			always_ff @(posedge clock or negedge rstN_ff) begin
				if (!rstN_ff) begin
					result_ff[gi] <= 1'b0;
				end else begin
					result_ff[gi] <= enable_ff[gi] && settled && syncStage_ff; // RULE10 RULE4
				end
			end

			assign wrCtrl = doWrite && wAligned && wLane0 && wIndex == CTRL_IDX[gi]; // RULE2
			assign hwChange = enable_ff[gi] && settled &&
				((enable_ff[gi] && syncStage_ff) != result_ff[gi]); // RULE12

			// Control fields written by software
			always_ff @(posedge clock or negedge rstN_ff) begin
				if (!rstN_ff) begin
					enable_ff[gi] <= CTRL_RESET[CTRL_ENABLE_BIT];
					posSel_ff[gi] <= CTRL_RESET[CTRL_POS_SEL_BIT];
					negSel_ff[gi] <= CTRL_RESET[CTRL_NEG_SEL_BIT];
					pinOe_ff[gi] <= CTRL_RESET[CTRL_PIN_OE_BIT];
				end else if (wrCtrl) begin
					enable_ff[gi] <= wData_ff[CTRL_ENABLE_BIT]; // RULE4
					posSel_ff[gi] <= wData_ff[CTRL_POS_SEL_BIT]; // RULE5
					negSel_ff[gi] <= wData_ff[CTRL_NEG_SEL_BIT]; // RULE5
					pinOe_ff[gi] <= wData_ff[CTRL_PIN_OE_BIT]; // RULE5
				end
			end

			// Change flag; hardware set wins over a clear
			always_ff @(posedge clock or negedge rstN_ff) begin
				if (!rstN_ff) begin
					flag_ff[gi] <= CTRL_RESET[CTRL_FLAG_BIT];
				end else if (hwChange) begin
					flag_ff[gi] <= 1'b1; // RULE12 RULE11
				end else if (wrCtrl) begin
					flag_ff[gi] <= wData_ff[CTRL_FLAG_BIT]; // RULE13
				end
			end

			// Pin enable and interrupt request
			always_ff @(posedge clock or negedge rstN_ff) begin
				if (!rstN_ff) begin
					comparatorPinOutEnable[gi] <= 1'b0;
					comparatorIrq[gi] <= 1'b0;
				end else begin
					comparatorPinOutEnable[gi] <= enable_ff[gi] && pinOe_ff[gi]; // RULE9
					comparatorIrq[gi] <= flag_ff[gi] && intCtrl_ff[INT_GLOBAL_EN_BIT] &&
						intCtrl_ff[INT_CMP_EN_LSB + gi]; // RULE12 RULE11
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// AXI4-Lite read channel
	// ----------------------------------------
	logic [9:0] rIndex;
	logic rAligned;
	logic [7:0] rByte;
	logic rHit;
	logic rSel;

	assign rIndex = s_axi_araddr[11:2];
	assign rSel = (rIndex == CMP_TWO_CTRL_IDX);
	assign rAligned = (s_axi_araddr[1:0] == 2'h0);

	// Read decode; reserved bits 7 and 6 read zero
	always_comb begin
		rByte = 8'h00;
		rHit = rAligned;
		if (rIndex == CMP_ONE_CTRL_IDX || rIndex == CMP_TWO_CTRL_IDX) begin
			rByte = {2'b00, enable_ff[rSel], posSel_ff[rSel], negSel_ff[rSel], pinOe_ff[rSel],
				result_ff[rSel], flag_ff[rSel]}; // RULE1 RULE10 RULE15
		end else if (rIndex == PORT0_DIG_IN_DIS_IDX) begin
			rByte = port0Disable_ff;
		end else if (rIndex == PORT0_PIN_READ_IDX) begin
			rByte = port0Read_ff; // RULE17
		end else if (rIndex == CMP_INT_CTRL_IDX) begin
			rByte = {5'h00, intCtrl_ff};
		end else begin
			rHit = 1'b0;
		end
	end

	// One read outstanding; data registered at acceptance
	always_ff @(posedge clock or negedge rstN_ff) begin
		if (!rstN_ff) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rHit ? {24'h000000, rByte} : 32'h00000000;
			s_axi_rresp <= rHit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end else if (!s_axi_rvalid) begin
			s_axi_arready <= 1'b1;
		end
	end

endmodule

/* File: dv/dcc_top_sva.sv */
`timescale 1ns/10ps
module dcc_top_sva
	import dcc_pkg::*;
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] port0InputBufferEnable,
	input wire logic [1:0] comparatorPinOut,
	input wire logic [1:0] comparatorIrq
);
	// ----------------
	// Bus and pin checks
	// ----------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
		else $error("read data changed while waiting");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
		else $error("upper read data not zero");
	a_err_data: assert property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR
		|-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while data pending");
	a_ibuf_cause: assert property (!$stable(port0InputBufferEnable)
		|-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("input buffer changed without a write");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_refused: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_irq: cover property ($rose(comparatorIrq[0]));
	c_pin: cover property ($rose(comparatorPinOut[0]));
endmodule

bind dcc_top dcc_top_sva chk_u (.clock(clock), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.port0InputBufferEnable(port0InputBufferEnable), .comparatorPinOut(comparatorPinOut),
	.comparatorIrq(comparatorIrq));

/* File: dv/tb_dual_comparator_control.sv */
`timescale 1ns/10ps
module tb_dual_comparator_control
	import dcc_pkg::*;
;
	logic clock, nrst, awValid, wValid, bReady, arValid, rReady, r;
	logic awReady, wReady, bValid, arReady, rValid;
	logic [11:0] awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [1:0] bResp, rResp, pinOut, pinOe, irq;
	logic [15:0] posA, posB;
	logic [7:0] extRef, p0Pins, ibufEn, v;
	int bad_count, checked;

	dcc_top dut_u (.clock(clock), .nrst(nrst), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
		.s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'hf), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		.posPinA(posA), .posPinB(posB), .externalReferencePin(extRef), .port0Pins(p0Pins),
		.port0InputBufferEnable(ibufEn), .comparatorPinOut(pinOut),
		.comparatorPinOutEnable(pinOe), .comparatorIrq(irq));

	// ----------------
	// Clock and helpers
	// ----------------
	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end

	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Bus write, address and data offered together
	task wr(input logic [11:0] a, input logic [7:0] d, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		awAddr <= a;
		wData <= {24'h0, d};
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		do begin
			@(posedge clock);
			if (awReady) awValid <= 1'b0;
			if (wReady) wValid <= 1'b0;
			n++;
		end while (!bValid && n < 50);
		chk({bValid, bResp}, {1'b1, er});
		bReady <= 1'b0;
	endtask

	// Bus read, byte left in v
	task rd(input logic [11:0] a, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge clock);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		do begin
			@(posedge clock);
			if (arReady) arValid <= 1'b0;
			n++;
		end while (!rValid && n < 50);
		v = rData[7:0];
		chk({rValid, rResp, rData[31:8]}, {1'b1, er, 24'h0});
		rReady <= 1'b0;
	endtask

	task rc(input logic [11:0] a, input logic [7:0] e);
		rd(a, RESP_OKAY);
		chk({24'h0, v}, {24'h0, e});
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		repeat (5000) @(posedge clock);
		bad_count++;
		$display("unexpected timeout at %0t", $time);
		end_sim();
	end

	// ----------------
	// Tests
	// ----------------
	initial begin
		{nrst, awValid, wValid, bReady, arValid, rReady} = 6'h0;
		{awAddr, arAddr, wData} = 56'h0;
		posA = {2{8'h90}};
		posB = {2{8'h10}};
		extRef = 8'ha0;
		p0Pins = 8'hff;
		bad_count = 0;
		checked = 0;
		repeat (10) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		chk({ibufEn, 2'h0, irq, pinOe, pinOut}, 16'hff00);
		rc(12'h2b0, 8'h00);
		rc(12'h2b4, 8'h00);
		rc(12'h3d8, 8'h00);
		rd(12'h004, RESP_SLVERR);
		wr(12'h2b1, 8'h20, RESP_SLVERR);
		$display("reset and decode done");
		wr(12'h2b0, 8'h16, RESP_OKAY);
		rc(12'h2b0, 8'h14);
		chk(pinOe, 2'h0);
		wr(12'h2b4, 8'h01, RESP_OKAY);
		rc(12'h2b4, 8'h01);
		wr(12'h2b4, 8'h00, RESP_OKAY);
		rc(12'h2b4, 8'h00);
		$display("control fields done");
		wr(12'h3d8, 8'h30, RESP_OKAY);
		rc(12'h3d8, 8'h30);
		chk(ibufEn, 8'hcf);
		rc(12'h200, 8'hcf);
		p0Pins <= 8'h5a;
		rc(12'h200, 8'h4a);
		$display("port input disable done");
		wr(12'h2b0, 8'h28, RESP_OKAY);
		wr(12'h2b4, 8'h28, RESP_OKAY);
		repeat (20) @(posedge clock);
		rc(12'h2b0, 8'h28);
		repeat (500) @(posedge clock);
		for (int c = 0; c < 2; c++) begin
			for (int i = 0; i < 8; i++) begin
				r = (i[2] ? 8'h10 : 8'h90) > (i[1] ? 8'h80 : 8'ha0);
				wr(12'h2b0 + 12'(4 * c), {3'h1, i[2:0], 2'h0}, RESP_OKAY);
				repeat (5) @(posedge clock);
				chk({pinOe[c], pinOut[c]}, {i[0], r & i[0]});
				rd(12'h2b0 + 12'(4 * c), RESP_OKAY);
				chk({24'h0, v & 8'hfe}, {24'h0, 3'h1, i[2:0], r, 1'b0});
			end
		end
		$display("configurations done");
		wr(12'h2b0, 8'h20, RESP_OKAY);
		repeat (5) @(posedge clock);
		wr(12'h2b0, 8'h20, RESP_OKAY);
		rc(12'h2b0, 8'h20);
		wr(12'h380, 8'h03, RESP_OKAY);
		repeat (3) @(posedge clock);
		chk(irq[0], 1'b0);
		posA[7:0] <= 8'hb0;
		repeat (6) @(posedge clock);
		chk(irq[0], 1'b1);
		rc(12'h2b0, 8'h23);
		wr(12'h380, 8'h02, RESP_OKAY);
		repeat (3) @(posedge clock);
		chk(irq[0], 1'b0);
		wr(12'h380, 8'h07, RESP_OKAY);
		repeat (3) @(posedge clock);
		chk(irq, 2'h1);
		wr(12'h2b4, 8'h3d, RESP_OKAY);
		repeat (3) @(posedge clock);
		chk(irq, 2'h3);
		wr(12'h2b0, 8'h24, RESP_OKAY);
		repeat (3) @(posedge clock);
		chk({irq[0], pinOut[0]}, 2'h1);
		rc(12'h2b0, 8'h26);
		$display("change flag done");
		wr(12'h2b0, 8'h04, RESP_OKAY);
		repeat (3) @(posedge clock);
		rc(12'h2b0, 8'h04);
		chk(pinOe[0], 1'b0);
		$display("disable done");
		end_sim();
	end
endmodule
